// >>> src/mvic_ctrl.sv
// vectored interrupt controller: arbitration, nesting and standby wake
module mvic_ctrl
   import mvic_pkg::*;
(
   input  wire logic                         clock,           // system clock
   input  wire logic                         reset,           // async, active high
   input  wire logic [mvic_pkg::NUM_SRC-1:0] src_req,         // source pending levels
   input  wire logic [mvic_pkg::NUM_VEC-1:0] high_sel,        // level select per vector
   input  wire logic                         ext0_level_det,  // ext zero in level mode
   input  wire logic                         ext1_level_det,  // ext one in level mode
   input  wire logic                         halt_mode,       // cpu in halt standby
   input  wire logic                         hold_mode,       // cpu in hold standby
   input  wire logic                         irq_ack,         // cpu takes presented vector
   input  wire logic                         irq_return,      // cpu returns from routine
   output logic                              irq_valid_q,     // a vector is presented
   output logic [mvic_pkg::VEC_W-1:0]        irq_vector_q,    // presented vector address
   output logic [1:0]                        irq_level_q,     // level of presented vector
   output logic [1:0]                        service_level_q, // level now in service
   output logic                              wake_q           // standby wake, a level
);
   import mvic_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // folded requests and their levels, two bits per vector
   logic [NUM_VEC-1:0]   vec_req;
   logic [NUM_VEC*2-1:0] vec_level;
   // per-vector levels unpacked once for the arbiter
   logic [1:0]           lvl_of [NUM_VEC];
   // vectors whose level beats the one in service
   logic [NUM_VEC-1:0]   eligible;
   // eligible vectors sorted by level
   logic [NUM_VEC-1:0]   at_top;
   logic [NUM_VEC-1:0]   at_high;
   logic [NUM_VEC-1:0]   at_low;
   logic [NUM_VEC-1:0]   win_mask;
   // arbiter result
   logic                 win_found;
   logic [IDX_W-1:0]     win_idx;
   logic [1:0]           win_level;
   // handshake with the cpu
   logic                 accept;
   logic                 leave;
   // nesting stack of interrupted levels
   logic [1:0]           stack_q [DEPTH];
   logic [1:0]           depth_q;
   logic                 stack_empty;
   logic                 stack_full;
   logic                 push;
   logic                 pop;
   logic [1:0]           popped_level;
   // standby release terms
   logic                 ext0_hold;
   logic                 ext1_hold;
   logic                 halt_wake;
   logic                 hold_wake;

   ////////////////////////////////////////////////////////////////////////////
   // vector address from entry index
   function automatic logic [VEC_W-1:0] vec_addr(input logic [IDX_W-1:0] idx);
      vec_addr = VEC_BASE + VEC_STEP * VEC_W'(idx);
   endfunction : vec_addr

   // true when level a strictly outranks level b
   function automatic logic outranks(input logic [1:0] a, input logic [1:0] b);
      outranks = (a > b);
   endfunction : outranks

   // index of the lowest set bit; zero when none is set
   function automatic logic [IDX_W-1:0] lowest_set(input logic [NUM_VEC-1:0] mask);
      lowest_set = '0;
      for (int i = NUM_VEC - 1; i >= 0; i--) begin
         if (mask[i]) begin
            lowest_set = IDX_W'(i);
         end
      end
   endfunction : lowest_set

   ////////////////////////////////////////////////////////////////////////////
   // source folding and level choice live in their own block
   mvic_source_map u_map (
      .src_req  (src_req),
      .high_sel (high_sel),
      .vec_req  (vec_req),
      .vec_level(vec_level)
   );

   // unpack the level pairs
   always_comb begin
      for (int i = 0; i < NUM_VEC; i++) begin
         lvl_of[i] = vec_level[i*2 +: 2];
      end
   end

   // equal or lower than the level in service is never offered
   always_comb begin
      for (int i = 0; i < NUM_VEC; i++) begin
         eligible[i] = vec_req[i] && outranks(lvl_of[i], service_level_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // arbitration in two stages: level first, then position
   always_comb begin
      for (int i = 0; i < NUM_VEC; i++) begin
         at_top[i]  = eligible[i] && (lvl_of[i] == MVIC_LVL_TOP);
         at_high[i] = eligible[i] && (lvl_of[i] == MVIC_LVL_HIGH);
         at_low[i]  = eligible[i] && (lvl_of[i] == MVIC_LVL_LOW);
      end
   end

   // highest level with anything eligible wins outright
   always_comb begin
      if (at_top != '0) begin
         win_level = MVIC_LVL_TOP;
         win_mask  = at_top;
      end else if (at_high != '0) begin
         win_level = MVIC_LVL_HIGH;
         win_mask  = at_high;
      end else if (at_low != '0) begin
         win_level = MVIC_LVL_LOW;
         win_mask  = at_low;
      end else begin
         win_level = LVL_NONE;
         win_mask  = '0;
      end
   end

   // lowest index is the smallest vector address
   assign win_found = (win_mask != '0);
   assign win_idx   = lowest_set(win_mask);

   ////////////////////////////////////////////////////////////////////////////
   // ack only counts while a vector stands; it beats a same-cycle return
   assign accept = irq_valid_q && irq_ack;
   assign leave  = irq_return && !accept;

   // stack bookkeeping; a push while full is unreachable since levels strictly rise
   assign stack_empty  = (depth_q == 2'h0);
   assign stack_full   = (depth_q == 2'(DEPTH));
   assign push         = accept && !stack_full;
   assign pop          = leave && !stack_empty;
   assign popped_level = stack_empty ? LVL_NONE : stack_q[depth_q - 2'h1];

   ////////////////////////////////////////////////////////////////////////////
   // presented flag: recomputed every cycle, down for one cycle after a take
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         irq_valid_q <= 1'b0;
      end else begin
         irq_valid_q <= win_found && !accept;
      end
   end

   // presented address; a higher arrival replaces it before the take
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         irq_vector_q <= '0;
      end else if (win_found && !accept) begin
         irq_vector_q <= vec_addr(win_idx);
      end else begin
         irq_vector_q <= '0;
      end
   end

   // presented level, zero when nothing stands
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         irq_level_q <= LVL_NONE;
      end else if (win_found && !accept) begin
         irq_level_q <= win_level;
      end else begin
         irq_level_q <= LVL_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // nesting depth; a return with nothing nested is ignored
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         depth_q <= 2'h0;
      end else if (push) begin
         depth_q <= depth_q + 2'h1;
      end else if (pop) begin
         depth_q <= depth_q - 2'h1;
      end
   end

   // saved levels; depth three covers low, high, top nesting
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < DEPTH; i++) begin
            stack_q[i] <= LVL_NONE;
         end
      end else if (push) begin
         stack_q[depth_q] <= service_level_q;
      end
   end

   // service level: raised on a take, restored on return
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         service_level_q <= LVL_NONE;
      end else if (accept) begin
         service_level_q <= irq_level_q;
      end else if (pop) begin
         service_level_q <= popped_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // halt ends on any request that could be taken now
   assign halt_wake = halt_mode && win_found;

   // edge-mode ext zero/one cannot wake hold: no clock runs to see the edge
   assign ext0_hold = src_req[SRC_EXT0] && ext0_level_det;
   assign ext1_hold = src_req[SRC_EXT1] && ext1_level_det;
   assign hold_wake = hold_mode
                    && (ext0_hold || ext1_hold
                        || src_req[SRC_EXT2] || src_req[SRC_EXT4]);

   // wake is a level while the condition holds in standby
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= halt_wake || hold_wake;
      end
   end
endmodule : mvic_ctrl

// >>> src/mvic_pkg.sv
// constants and types shared by the vectored interrupt controller
package mvic_pkg;
   localparam int NUM_SRC = 18;
   localparam int NUM_VEC = 10;
   localparam int VEC_W   = 17;
   localparam int IDX_W   = 4;
   localparam int DEPTH   = 3;
   // vector address of entry 0 and the step between entries
   localparam logic [VEC_W-1:0] VEC_BASE = 17'h00003;
   localparam logic [VEC_W-1:0] VEC_STEP = 17'h00008;
   // source bit positions
   localparam int SRC_EXT0 = 0;
   localparam int SRC_EXT1 = 1;
   localparam int SRC_EXT2 = 2;
   localparam int SRC_TIMER0_LOW     = 3;
   localparam int SRC_EXT4           = 4;
   localparam int SRC_EXT3           = 5;
   localparam int SRC_BASE           = 6;
   localparam int SRC_TIMER0_HIGH    = 7;
   localparam int SRC_TIMER1_LOW     = 8;
   localparam int SRC_TIMER1_HIGH    = 9;
   localparam int SRC_URX            = 10;
   localparam int SRC_SIO            = 11;
   localparam int SRC_UTX            = 12;
   localparam int SRC_ADC            = 13;
   localparam int SRC_TIMER_SIX      = 14;
   localparam int SRC_TIMER_SEVEN    = 15;
   localparam int SRC_COMPARATOR_SIX = 16;
   localparam int SRC_SURG           = 17;
   // priority levels, ordered so that numeric compare gives precedence
   typedef enum logic [1:0] {
      MVIC_LVL_NONE = 2'h0,
      MVIC_LVL_LOW  = 2'h1,
      MVIC_LVL_HIGH = 2'h2,
      MVIC_LVL_TOP  = 2'h3
   } mvic_level_t;
   localparam logic [1:0] LVL_NONE = 2'h0;
endpackage : mvic_pkg

// >>> src/mvic_source_map.sv
// folds request sources onto vector request lines and grants level
module mvic_source_map
   import mvic_pkg::*;
(
   input  wire logic [mvic_pkg::NUM_SRC-1:0]   src_req,    // per-source pending flags
   input  wire logic [mvic_pkg::NUM_VEC-1:0]   high_sel,   // 1: high/top level, 0: low
   output logic [mvic_pkg::NUM_VEC-1:0]        vec_req,    // per-vector request
   output logic [mvic_pkg::NUM_VEC*2-1:0]      vec_level   // per-vector level, 2 bits each
);
   import mvic_pkg::*;

   // shared vectors or their sources together
   always_comb begin
      vec_req[0] = src_req[SRC_EXT0];
      vec_req[1] = src_req[SRC_EXT1];
      vec_req[2] = src_req[SRC_EXT2] | src_req[SRC_TIMER0_LOW]
                 | src_req[SRC_EXT4];
      vec_req[3] = src_req[SRC_EXT3] | src_req[SRC_BASE];
      vec_req[4] = src_req[SRC_TIMER0_HIGH];
      vec_req[5] = src_req[SRC_TIMER1_LOW] | src_req[SRC_TIMER1_HIGH];
      vec_req[6] = src_req[SRC_URX];
      vec_req[7] = src_req[SRC_SIO] | src_req[SRC_UTX];
      vec_req[8] = src_req[SRC_ADC] | src_req[SRC_TIMER_SIX]
                 | src_req[SRC_TIMER_SEVEN];
      vec_req[9] = src_req[SRC_COMPARATOR_SIX] | src_req[SRC_SURG];
   end
   // first two vectors choose top or low, the rest high or low
   always_comb begin
      for (int i = 0; i < NUM_VEC; i++) begin
         if (!high_sel[i])
            vec_level[i*2 +: 2] = MVIC_LVL_LOW;
         else if (i < 2)
            vec_level[i*2 +: 2] = MVIC_LVL_TOP;
         else
            vec_level[i*2 +: 2] = MVIC_LVL_HIGH;
      end
   end
endmodule : mvic_source_map

// >>> tb/mvic_cpu_model.sv
// cpu core stand-in: takes presented vectors, returns on command
module mvic_cpu_model (
   input  wire logic                       clock,        // system clock
   input  wire logic                       reset,        // async reset
   input  wire logic                       take_en,      // may accept
   input  wire logic [3:0]                 lat,          // wait before ack
   input  wire logic                       ret_cmd,      // end routine
   input  wire logic                       irq_valid_q,  // presented
   input  wire logic [mvic_pkg::VEC_W-1:0] irq_vector_q, // vector
   input  wire logic [1:0]                 irq_level_q,  // its level
   output logic                            irq_ack,      // take pulse
   output logic                            irq_return,   // return pulse
   output logic [mvic_pkg::VEC_W-1:0]      got_vec,      // last taken
   output logic [1:0]                      got_lvl,      // its level
   output int                              taken         // takes so far
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_q;
   // slow cores wait lat cycles; ack is one cycle wide
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         irq_ack <= 1'b0;
         wait_q  <= 4'h0;
      end else if (irq_ack || !(take_en && irq_valid_q)) begin
         irq_ack <= 1'b0;
         wait_q  <= 4'h0;
      end else if (wait_q == lat) begin
         irq_ack <= 1'b1;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
   ////////////////////////////////////////////////////////////
   // record the handover only where the take really lands
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         taken      <= 0;
         irq_return <= 1'b0;
      end else begin
         irq_return <= ret_cmd;
         if (irq_ack && irq_valid_q) begin
            taken   <= taken + 1;
            got_vec <= irq_vector_q;
            got_lvl <= irq_level_q;
         end
      end
   end
endmodule : mvic_cpu_model

// >>> tb/mvic_ctrl_properties.sv
// port assertions for the vectored interrupt controller
module mvic_ctrl_properties (
   input wire logic                        clock,           // system clock
   input wire logic                        reset,           // async reset
   input wire logic [mvic_pkg::NUM_SRC-1:0] src_req,        // sources
   input wire logic                        halt_mode,       // halt standby
   input wire logic                        hold_mode,       // hold standby
   input wire logic                        irq_ack,         // cpu take
   input wire logic                        irq_valid_q,     // presented
   input wire logic [mvic_pkg::VEC_W-1:0]  irq_vector_q,    // vector
   input wire logic [1:0]                  irq_level_q,     // its level
   input wire logic [1:0]                  service_level_q, // in service
   input wire logic                        wake_q           // wake
);
   timeunit 1ns;
   timeprecision 1ps;
   import mvic_pkg::*;
   // one domain, so clock and reset are set once
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////
   a_vec_grid: assert property (
      irq_valid_q |-> irq_vector_q[2:0] == 3'h3 && irq_vector_q < 17'h50)
      else $error("vector off table");
   a_idle_none: assert property (src_req == '0 |=> !irq_valid_q)
      else $error("vector with no source");
   a_nest_above: assert property (irq_valid_q |-> irq_level_q > service_level_q)
      else $error("level not above service");
   a_ext_top_low: assert property (
      irq_valid_q && irq_vector_q < 17'h13 |-> irq_level_q != 2'h2)
      else $error("ext vector at high");
   a_rest_hi_low: assert property (
      irq_valid_q && irq_vector_q > 17'hb |-> irq_level_q != 2'h3)
      else $error("shared vector at top");
   a_ack_drop: assert property (irq_valid_q && irq_ack |=> !irq_valid_q)
      else $error("vector kept after take");
   a_svc_raise: assert property (
      irq_valid_q && irq_ack |=> service_level_q == $past(irq_level_q))
      else $error("service level not raised");
   a_wake_sby: assert property (wake_q |-> $past(halt_mode || hold_mode))
      else $error("wake outside standby");
endmodule : mvic_ctrl_properties
bind mvic_ctrl mvic_ctrl_properties u_props (.clock, .reset, .src_req, .halt_mode, .hold_mode,
   .irq_ack, .irq_valid_q, .irq_vector_q, .irq_level_q, .service_level_q, .wake_q);

// >>> tb/test_mvic_ctrl.sv
// self-checking bench for the vectored interrupt controller
module test_mvic_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import mvic_pkg::*;
   logic clock = 1'b0, reset = 1'b1, halt_mode = 1'b0, hold_mode = 1'b0, take_en = 1'b0;
   logic ext0_level_det = 1'b0, ext1_level_det = 1'b0, ret_cmd = 1'b0;
   logic [NUM_SRC-1:0] src_req = '0;
   logic [NUM_VEC-1:0] high_sel = '0;
   logic [3:0] lat = 4'h0;
   logic irq_ack, irq_return, irq_valid_q, wake_q;
   logic [VEC_W-1:0] irq_vector_q, got_vec;
   logic [1:0] irq_level_q, service_level_q, got_lvl;
   int taken, miscompares = 0, check_count = 0, cyc = 0;
   localparam int src_of[10] = '{SRC_EXT0, SRC_EXT1, SRC_EXT4, SRC_EXT3, SRC_TIMER0_HIGH,
                                 SRC_TIMER1_LOW, SRC_URX, SRC_SIO, SRC_TIMER_SIX,
                                 SRC_COMPARATOR_SIX};
   mvic_ctrl DUT (.clock, .reset, .src_req, .high_sel, .ext0_level_det, .ext1_level_det,
      .halt_mode, .hold_mode, .irq_ack, .irq_return, .irq_valid_q, .irq_vector_q, .irq_level_q,
      .service_level_q, .wake_q);
   mvic_cpu_model cpu (.clock, .reset, .take_en, .lat, .ret_cmd, .irq_valid_q, .irq_vector_q,
      .irq_level_q, .irq_ack, .irq_return, .got_vec, .got_lvl, .taken);
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   // let the cpu take one vector, bounded wait
   task automatic grab(input logic [16:0] vec, input logic [1:0] lvl);
      int t0;
      t0 = taken;
      @(posedge clock) take_en <= 1'b1;
      for (int i = 0; i < 30 && taken == t0; i++) @(negedge clock);
      @(posedge clock) take_en <= 1'b0;
      chk(got_vec, vec);
      chk(got_lvl, lvl);
   endtask : grab
   task automatic ret;
      @(posedge clock) ret_cmd <= 1'b1;
      @(posedge clock) ret_cmd <= 1'b0;
      repeat (3) @(negedge clock);
   endtask : ret
   task automatic wake_is(input logic exp);
      repeat (3) @(negedge clock);
      chk(wake_q, exp);
   endtask : wake_is
   // one source per vector, level select and ack latency varied
   task automatic t_map;
      for (int n = 0; n < 10; n++) begin
         @(posedge clock) begin
            src_req  <= NUM_SRC'(1) << src_of[n];
            high_sel <= {NUM_VEC{n[0]}};
            lat      <= n[3:0];
         end
         grab(17'(VEC_BASE + VEC_STEP * n), n[0] ? (n < 2 ? 2'h3 : 2'h2) : 2'h1);
         @(posedge clock) src_req <= '0;
         ret();
      end
   endtask : t_map
   // all pending: level first, nesting, restore, then lowest vector
   task automatic t_prio;
      @(posedge clock) begin
         src_req  <= '1;
         high_sel <= 10'h200;
      end
      grab(17'h4b, 2'h2);
      repeat (4) @(negedge clock) chk(irq_valid_q, 1'b0);
      @(posedge clock) high_sel <= 10'h201;
      grab(17'h3, 2'h3);
      chk(service_level_q, 2'h3);
      ret();
      chk(service_level_q, 2'h2);
      @(posedge clock) high_sel <= '0;
      ret();
      chk(service_level_q, 2'h0);
      grab(17'h3, 2'h1);
      @(posedge clock) src_req <= '0;
      ret();
   endtask : t_prio
   // halt wakes on any source that could be taken now, hold on level-mode ext zero/one and on ext two/four
   task automatic t_wake;
      @(posedge clock) begin
         src_req   <= NUM_SRC'(1) << SRC_TIMER1_LOW;
         halt_mode <= 1'b1;
      end
      wake_is(1'b1);
      @(posedge clock) begin
         halt_mode <= 1'b0;
         hold_mode <= 1'b1;
      end
      wake_is(1'b0);
      @(posedge clock) src_req <= NUM_SRC'(1) << SRC_EXT0;
      wake_is(1'b0);
      @(posedge clock) ext0_level_det <= 1'b1;
      wake_is(1'b1);
      @(posedge clock) begin
         ext0_level_det <= 1'b0;
         src_req        <= NUM_SRC'(1) << SRC_EXT1;
      end
      wake_is(1'b0);
      @(posedge clock) ext1_level_det <= 1'b1;
      wake_is(1'b1);
      @(posedge clock) src_req <= NUM_SRC'(1) << SRC_EXT2;
      wake_is(1'b1);
      @(posedge clock) src_req <= NUM_SRC'(1) << SRC_EXT4;
      wake_is(1'b1);
   endtask : t_wake
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////
   initial forever #5 clock = ~clock;
   // hang guard, well above the expected run length
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      t_map();
      $display("vector map test done");
      t_prio();
      $display("priority test done");
      t_wake();
      $display("wake test done");
      tally_and_finish();
   end
endmodule : test_mvic_ctrl
